// file: buck_regs_assertions.sv
// bus and converter assertions for the buck register slice
`timescale 1ns/1ns
module buck_regs_assertions (
  input logic clk_i,
  input logic rst_i,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic [31:0] wb_dat_o,
  input logic standby_i,
  input logic sleep_i,
  input logic turnoff_i,
  input logic [3:0] buck1_mode_o,
  input logic buck1_enable_o,
  input logic [1:0] buck1_state_o
);
  default clocking @(posedge clk_i);
  endclocking
  logic rst_q;
  // stretch reset one edge: the bench drops rst_i by nba on the release edge
  always_ff @(posedge clk_i) begin
    rst_q <= rst_i;
  end
  default disable iff (rst_i || rst_q);
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire rd = take & !wb_we_i;
  wire [5:0] idx = wb_adr_i[7:2];
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    take |=> s_pulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_volt_rd;
    rd && idx inside {6'h20, 6'h21, 6'h22} |=> wb_dat_o[31:5] == 27'h0;
  endproperty
  a_volt_rd: assert property (p_volt_rd) else $error("voltage spare bits set");
  property p_mode_rd;
    rd && idx == 6'h23 |=> wb_dat_o[7:6] == 2'h0 && !wb_dat_o[4];
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode spare bits set");
  property p_unmap;
    rd && idx == 6'h3F |=> wb_dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_mode_wr;
    logic [3:0] d;
    (take && wb_we_i && wb_sel_i[0] && idx == 6'h23, d = wb_dat_i[3:0]) |-> ##2 buck1_mode_o == d;
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode output missed write");
  property p_norm;
    (!standby_i && !sleep_i && !turnoff_i) [*2] |-> buck1_state_o == 2'h0;
  endproperty
  a_norm: assert property (p_norm) else $error("normal state missed");
  property p_stby;
    (standby_i && !sleep_i && !turnoff_i) [*2] |-> buck1_state_o == 2'h1;
  endproperty
  a_stby: assert property (p_stby) else $error("standby state missed");
  property p_sleep;
    (sleep_i && !turnoff_i) [*2] |-> buck1_state_o == 2'h3;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep state missed");
  property p_off;
    buck1_state_o == 2'h2 |-> $past(turnoff_i);
  endproperty
  a_off: assert property (p_off) else $error("off without turn-off");
  property p_en;
    $stable(buck1_state_o) [*3] |-> buck1_enable_o == (buck1_state_o != 2'h2);
  endproperty
  a_en: assert property (p_en) else $error("enable disagrees with state");
endmodule
bind buck_regulator_config_regs buck_regs_assertions u_chk (.*);

// file: buck_regs_consts.svh
// constants for the buck converter register slice
`ifndef BUCK_REGS_CONSTS_SVH
`define BUCK_REGS_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_W 6
`define IDX_SCRATCH 6'h1F
`define IDX_NORMAL_VOLT 6'h20
`define IDX_STANDBY_VOLT 6'h21
`define IDX_SLEEP_VOLT 6'h22
`define IDX_MODE_SELECT 6'h23
`define IDX_STATUS 6'h30

// ----------------------------------------------------------------
// bus address fields
// ----------------------------------------------------------------
`define ADR_W 8
`define ADR_IDX_MSB 7
`define ADR_IDX_LSB 2

// ----------------------------------------------------------------
// field layouts
// ----------------------------------------------------------------
`define BYTE_W 8
`define VOLT_W 5
`define SWMODE_W 4
`define TARGET_BIT 5
`define STAT_SETPOINT_LSB 0
`define STAT_STATE_LSB 5
`define STAT_STATE_W 2
`define STAT_ENABLE_BIT 7

// ----------------------------------------------------------------
// reset values and zero fill for reads and the idle bus
// ----------------------------------------------------------------
`define SCRATCH_CLEAR 8'h00
`define TARGET_RESET 1'h0
`define READ_ZERO 8'h00
`define BUS_ZERO 32'h0000_0000

`endif

// file: buck_regs_pkg.sv
// types shared by the buck converter register slice
package buck_regs_pkg;
`include "buck_regs_consts.svh"

  // power state as seen by the first buck converter, gray coded
  typedef enum logic [1:0] {
    PS_NORMAL = 2'h0,
    PS_STANDBY = 2'h1,
    PS_SLEEP = 2'h3,
    PS_OFF = 2'h2
  } power_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } bus_state_t;

  typedef struct packed {
    logic por_meta;
    logic por_sync;
    logic [`BYTE_W-1:0] scratch;
    logic [`VOLT_W-1:0] normal_volt;
    logic [`VOLT_W-1:0] standby_volt;
    logic [`VOLT_W-1:0] sleep_volt;
    logic [`SWMODE_W-1:0] sw_mode;
    logic turnoff_target;
    power_state_t pstate;
    logic [`VOLT_W-1:0] setpoint;
    logic [`SWMODE_W-1:0] mode_out;
    logic enable;
  } regs_state_t;
endpackage

// file: buck_regulator_config_regs.sv
// register slice: backup scratch byte and first buck converter control
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "buck_regs_consts.svh"
module buck_regulator_config_regs
  import buck_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic backup_cell_por_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [`VOLT_W-1:0] otp_normal_volt_i,
  input wire logic [`VOLT_W-1:0] otp_standby_volt_i,
  input wire logic [`VOLT_W-1:0] otp_sleep_volt_i,
  input wire logic [`SWMODE_W-1:0] otp_sw_mode_i,
  input wire logic standby_i,
  input wire logic sleep_i,
  input wire logic turnoff_i,
  output logic [`VOLT_W-1:0] buck1_setpoint_o,
  output logic [`SWMODE_W-1:0] buck1_mode_o,
  output logic buck1_enable_o,
  output logic [1:0] buck1_state_o
);
  regs_state_t st;
  regs_state_t next_st;
  reg_access_if acc ();

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function automatic logic [`BYTE_W-1:0] read_reg(
    input logic [`IDX_W-1:0] idx,
    input regs_state_t s
  );
    logic [`BYTE_W-1:0] r;
    r = `READ_ZERO;
    case (idx)
      `IDX_SCRATCH: r = s.scratch;
      `IDX_NORMAL_VOLT: r[`VOLT_W-1:0] = s.normal_volt;
      `IDX_STANDBY_VOLT: r[`VOLT_W-1:0] = s.standby_volt;
      `IDX_SLEEP_VOLT: r[`VOLT_W-1:0] = s.sleep_volt;
      `IDX_MODE_SELECT: begin
        r[`SWMODE_W-1:0] = s.sw_mode;
        r[`TARGET_BIT] = s.turnoff_target;
      end
      `IDX_STATUS: begin
        r[`STAT_SETPOINT_LSB +: `VOLT_W] = s.setpoint;
        r[`STAT_STATE_LSB +: `STAT_STATE_W] = s.pstate;
        r[`STAT_ENABLE_BIT] = s.enable;
      end
      default: r = `READ_ZERO;
    endcase
    return r;
  endfunction

  assign acc.rdata = read_reg(acc.idx, st);

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg_bus_slave u_bus (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .acc(acc.bus)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.por_meta = backup_cell_por_n_i;
    next_st.por_sync = st.por_meta;

    // register writes, no lock or mode gating
    if (acc.wr) begin
      unique case (acc.idx)
        `IDX_SCRATCH: next_st.scratch = acc.wdata;
        `IDX_NORMAL_VOLT: next_st.normal_volt = acc.wdata[`VOLT_W-1:0];
        `IDX_STANDBY_VOLT: next_st.standby_volt = acc.wdata[`VOLT_W-1:0];
        `IDX_SLEEP_VOLT: next_st.sleep_volt = acc.wdata[`VOLT_W-1:0];
        `IDX_MODE_SELECT: begin
          next_st.sw_mode = acc.wdata[`SWMODE_W-1:0];
          next_st.turnoff_target = acc.wdata[`TARGET_BIT];
        end
        default: next_st.scratch = st.scratch;
      endcase
    end

    // power state tracking
    if (turnoff_i) begin
      next_st.pstate = st.turnoff_target ? PS_SLEEP : PS_OFF;
    end else if (sleep_i) begin
      next_st.pstate = PS_SLEEP;
    end else if (standby_i) begin
      next_st.pstate = PS_STANDBY;
    end else begin
      next_st.pstate = PS_NORMAL;
    end

    // converter drive
    next_st.mode_out = st.sw_mode;
    unique case (st.pstate)
      PS_NORMAL: begin
        next_st.setpoint = st.normal_volt;
        next_st.enable = 1'b1;
      end
      PS_STANDBY: begin
        next_st.setpoint = st.standby_volt;
        next_st.enable = 1'b1;
      end
      PS_SLEEP: begin
        next_st.setpoint = st.sleep_volt;
        next_st.enable = 1'b1;
      end
      PS_OFF: begin
        next_st.setpoint = st.sleep_volt;
        next_st.enable = 1'b0;
      end
    endcase

    // main reset reloads otp fields and leaves scratch alone
    if (rst_i) begin
      next_st.normal_volt = otp_normal_volt_i;
      next_st.standby_volt = otp_standby_volt_i;
      next_st.sleep_volt = otp_sleep_volt_i;
      next_st.sw_mode = otp_sw_mode_i;
      next_st.turnoff_target = `TARGET_RESET;
      next_st.pstate = PS_NORMAL;
      next_st.setpoint = otp_normal_volt_i;
      next_st.mode_out = otp_sw_mode_i;
      next_st.enable = 1'b0;
      next_st.scratch = st.scratch;
    end

    // coin cell reset wins over writes
    if (!st.por_sync) begin
      next_st.scratch = `SCRATCH_CLEAR;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign buck1_setpoint_o = st.setpoint;
  assign buck1_mode_o = st.mode_out;
  assign buck1_enable_o = st.enable;
  assign buck1_state_o = st.pstate;
endmodule

// file: reg_access_if.sv
// decoded register access between bus slave and register file
`timescale 1ns/1ns
interface reg_access_if;
  logic wr;
  logic [5:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bus (
    output wr,
    output idx,
    output wdata,
    input rdata
  );

  modport regs (
    input wr,
    input idx,
    input wdata,
    output rdata
  );
endinterface

// file: reg_bus_slave.sv
// classic wishbone slave for the buck register slice
`timescale 1ns/1ns
`include "buck_regs_consts.svh"
module reg_bus_slave
  import buck_regs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  reg_access_if.bus acc
);
  bus_state_t st;
  bus_state_t next_st;
  logic req;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~st.ack;
  assign acc.wr = req & wb_we_i & wb_sel_i[0];
  assign acc.idx = wb_adr_i[`ADR_IDX_MSB:`ADR_IDX_LSB];
  assign acc.wdata = wb_dat_i[`BYTE_W-1:0];

  // ----------------------------------------------------------------
  // one-cycle registered answer
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.dat = req ? {24'h00_0000, acc.rdata} : `BUS_ZERO;
    if (rst_i) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.dat;
endmodule

// file: testbench.sv
// self-checking bench for the buck register slice
`timescale 1ns/1ns
module testbench;
  import buck_regs_pkg::*;
  logic clk_i = 0, rst_i = 1, backup_cell_por_n_i = 0;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, buck1_enable_o;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0, otp_sw_mode_i = 0, buck1_mode_o;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  logic [4:0] otp_normal_volt_i = 0, otp_standby_volt_i = 0, otp_sleep_volt_i = 0;
  logic [4:0] buck1_setpoint_o;
  logic standby_i = 0, sleep_i = 0, turnoff_i = 0;
  logic [1:0] buck1_state_o, s;
  logic [7:0] m [64];
  logic [5:0] ids [6] = '{6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h3F};
  int err_count = 0, n_tests = 0, seed = 32'h0F4B, e;
  always #5 clk_i = ~clk_i;
  buck_regulator_config_regs DUT (.*);
  // ----
  // compare, bus and model tasks
  // ----
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  function automatic logic [7:0] msk(logic [5:0] i);
    return i == 6'h1F ? 8'hFF : i == 6'h23 ? 8'h2F : i inside {6'h20, 6'h21, 6'h22} ? 8'h1F : 8'h0;
  endfunction
  task automatic wb(logic w, logic [5:0] i, logic [7:0] d, logic sl);
    int n;
    n = 0;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'h3};
    wb_dat_i <= {24'hA5A5A5, d};
    wb_sel_i <= {3'h7, sl};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk("ack", 8'h2, 8'(n));
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (w && sl) m[i] = d & msk(i);
    if (!w) chk("read", m[i], wb_dat_o[7:0]);
    @(posedge clk_i);
  endtask
  task automatic chk_pwr;
    repeat (3) @(posedge clk_i);
    s = turnoff_i ? (m[6'h23][5] ? 2'h3 : 2'h2) : sleep_i ? 2'h3 : standby_i ? 2'h1 : 2'h0;
    chk("state", {6'h0, s}, {6'h0, buck1_state_o});
    chk("setpoint", m[s == 0 ? 6'h20 : s == 1 ? 6'h21 : 6'h22], {3'h0, buck1_setpoint_o});
    chk("mode", {4'h0, m[6'h23][3:0]}, {4'h0, buck1_mode_o});
    chk("enable", {7'h0, s != 2}, {7'h0, buck1_enable_o});
    m[6'h30] = {s != 2'h2, s, m[s == 0 ? 6'h20 : s == 1 ? 6'h21 : 6'h22][4:0]};
    wb(0, 6'h30, 8'h0, 1);
  endtask
  task automatic rst;
    {otp_normal_volt_i, otp_standby_volt_i, otp_sleep_volt_i, otp_sw_mode_i} <= 19'($random(seed));
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    m[6'h20] = {3'h0, otp_normal_volt_i};
    m[6'h21] = {3'h0, otp_standby_volt_i};
    m[6'h22] = {3'h0, otp_sleep_volt_i};
    m[6'h23] = {4'h0, otp_sw_mode_i};
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    m[6'h3F] = 8'h0;
    m[6'h1F] = 8'h0;
    rst;
    repeat (3) @(posedge clk_i);
    backup_cell_por_n_i <= 1;
    for (int k = 0; k < 6; k++) wb(0, ids[k], 8'h0, 1);
    repeat (60) begin
      e = $random(seed);
      wb(e[8], ids[$unsigned(e[18:16]) % 6], e[7:0], e[9] | e[10]);
      {turnoff_i, sleep_i, standby_i} <= e[13:11];
      chk_pwr;
    end
    wb(1, 6'h1F, 8'h9C, 1);
    rst;
    for (int k = 0; k < 6; k++) wb(0, ids[k], 8'h0, 1);
    backup_cell_por_n_i <= 0;
    repeat (4) @(posedge clk_i);
    backup_cell_por_n_i <= 1;
    m[6'h1F] = 8'h0;
    wb(0, 6'h1F, 8'h0, 1);
    conclude;
  end
  initial begin
    #100000;
    err_count++;
    conclude;
  end
endmodule
